// ### dv/ecp_link_asserts.sv
// ecp_link_asserts: timing and framing checks on the configuration link
`timescale 1ns/10ps
`default_nettype none
module ecp_link_asserts #(
   parameter int HALF_MAX = ecp_pkg::HALF_MAX_INT
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic dev_rst_i,
   input wire logic sclk_i,
   input wire logic din_i,
   input wire logic sel_i,
   input wire logic dout_i,
   input wire logic dout_oe_n_i
);
   logic prev_r;
   logic sel_r;
   logic b0_r;
   logic [3:0] rcnt_r;
   logic [15:0] lvl_r;
   logic [15:0] scnt_r;
   logic rise;
   logic fall;
   assign rise = sclk_i & ~prev_r;
   assign fall = ~sclk_i & prev_r;
   // level length and time since select change saturate, so a long run cannot wrap them
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         prev_r <= 1'b1;
         sel_r <= 1'b1;
         b0_r <= 1'b0;
         rcnt_r <= 4'h0;
         lvl_r <= 16'h0;
         scnt_r <= 16'h0;
      end else begin
         prev_r <= sclk_i;
         sel_r <= sel_i;
         if (sclk_i != prev_r) begin
            lvl_r <= 16'h1;
         end else if (lvl_r != 16'hffff) begin
            lvl_r <= lvl_r + 16'h1;
         end
         if (sel_i != sel_r) begin
            scnt_r <= 16'h1;
         end else if (scnt_r != 16'hffff) begin
            scnt_r <= scnt_r + 16'h1;
         end
         rcnt_r <= sel_i ? 4'h0 : rcnt_r + {3'h0, rise};
         if (rise && rcnt_r == 4'h0) begin
            b0_r <= din_i;
         end
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   AST_SEL_CLK_HIGH: assert property ($changed(sel_i) |-> sclk_i && prev_r)
      else $error("select changed while clock low");
   AST_SEL_PINS: assert property (sel_i |-> dout_oe_n_i && din_i && sclk_i)
      else $error("pins not idle in readout mode");
   AST_LOW_HALF: assert property (rise |-> (lvl_r >= ecp_pkg::HALF_MIN_CYC)
      && (lvl_r <= HALF_MAX))
      else $error("clock low phase out of range");
   AST_GAP_HIGH: assert property (fall |-> lvl_r >= ecp_pkg::GAP_HIGH_CYC)
      else $error("clock high gap too short");
   AST_SEL_SETTLE: assert property (fall |-> scnt_r >= ecp_pkg::SEL_SETTLE_CYC)
      else $error("frame too soon after select change");
   AST_DOUT_EDGE: assert property ($changed(dout_i) |-> fall)
      else $error("data out changed off falling clock");
   AST_OE_EDGE: assert property (!sel_i && !sel_r
      && $fell(dout_oe_n_i) |-> fall)
      else $error("drive started off falling clock");
   AST_OPCODE: assert property (rise && rcnt_r == 4'h1 |-> din_i != b0_r)
      else $error("opcode not 10 or 01");
   AST_READ_FILL: assert property (rise && rcnt_r[3] && b0_r |-> din_i)
      else $error("input not high during read data");
   AST_READ_DRIVE: assert property (rise && rcnt_r[3] && b0_r && !dev_rst_i
      |-> !dout_oe_n_i)
      else $error("read data not driven");
   AST_QUIET: assert property (rise && !rcnt_r[3] |-> dout_oe_n_i)
      else $error("output driven during command");
   // main traffic seen
   COV_READ: cover property (rise && rcnt_r == 4'hf && b0_r);
   COV_WRITE: cover property (rise && rcnt_r == 4'hf && !b0_r);
   COV_SEL_LOW: cover property ($fell(sel_i));
   COV_SEL_HIGH: cover property ($rose(sel_i));
endmodule
`default_nettype wire

// ### dv/encoder_spi_otp_config_port_tb.sv
// encoder_spi_otp_config_port_tb: host and device joined, driven over apb
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module encoder_spi_otp_config_port_tb;
   localparam int HM = 200;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic dev_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er, unlocked;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [55:0] shadow, otp;
   logic [7:0] keys[3];
   int mismatches = 0;
   int checked = 0;
   int m_reg[64];
   int m_otp[7];
   ecp_link_if lnk();
   ecp_host #(.HALF_MAX(HM)) ecp_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .lnk(lnk.host));
   ecp_dev ecp_dev_i (.lnk(lnk.dev), .rst_i(dev_rst), .shadow_o(shadow), .otp_o(otp),
      .unlocked_o(unlocked));
   ecp_link_asserts #(.HALF_MAX(HM)) ecp_link_asserts_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .dev_rst_i(dev_rst), .sclk_i(lnk.shared_serial_clock_pin),
      .din_i(lnk.shared_load_or_serial_input_pin), .sel_i(lnk.protocol_select_input),
      .dout_i(lnk.dout), .dout_oe_n_i(lnk.dout_oe_n));
   // 200 mhz system clock
   always #2.5 clk_sys_i = ~clk_sys_i;
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      @(posedge clk_sys_i);
      while (pready !== 1'b1) @(posedge clk_sys_i);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // poll status until the host is idle
   task automatic idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, ecp_pkg::OFS_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 3000);
      `CHK("busy", 1'b0, rd[0])
   endtask
   // one link frame through the command register
   task automatic spi(input logic w, input logic [5:0] a, input logic [7:0] d);
      apb(1'b1, ecp_pkg::OFS_CMD, {15'h0, w, 2'h0, a, d});
      idle();
   endtask
   // model of a device write: lock, store, burn
   function automatic void mwr(int a, int d);
      if (a < 32 && (a <= 3 || a == 16 || a == 17 || a == 18 || a == 27 ||
            m_reg[16] == 32'(ecp_pkg::KEY_UNLOCK))) begin
         m_reg[a] = d;
         for (int i = 0; i < 7; i++) begin
            if ((i < 2 && a == 17 && d == 32'(ecp_pkg::KEY_BURN_RSV)) ||
                (i >= 2 && i < 4 && a == 18 && d == 32'(ecp_pkg::KEY_BURN_ZERO)) ||
                (i >= 4 && a == 19 && d == 32'(ecp_pkg::KEY_BURN_CFG))) begin
               m_otp[i] = m_reg[i];
            end
         end
      end
   endfunction
   // write frame, then compare shadow, burned image and unlock state
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      spi(1'b1, a, d);
      mwr(int'(a), int'(d));
      for (int i = 0; i < 7; i++) begin
         `CHK("shadow", 8'(m_reg[i]), shadow[8*i+:8])
         `CHK("otp", 8'(m_otp[i]), otp[8*i+:8])
      end
      `CHK("unlocked", m_reg[16] == 32'(ecp_pkg::KEY_UNLOCK), unlocked)
   endtask
   // read frame, then compare the returned byte
   task automatic rdc(input logic [5:0] a);
      spi(1'b0, a, 8'h0);
      apb(1'b0, ecp_pkg::OFS_RDATA, 32'h0);
      `CHK("rdata", 8'((a < 6'h20) ? m_reg[a] : 0), rd[7:0])
   endtask
   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (98000) @(posedge clk_sys_i);
      mismatches++;
      finish_test();
   end
   // main sequence
   initial begin
      void'($urandom(32'h1f54));
      keys = '{ecp_pkg::KEY_BURN_RSV, ecp_pkg::KEY_BURN_ZERO, ecp_pkg::KEY_BURN_CFG};
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      apb(1'b0, ecp_pkg::OFS_STATUS, 32'h0);
      `CHK("status", 32'h2, rd)
      apb(1'b1, 12'h020, 32'hffff);
      `CHK("pslverr", 1'b1, er)
      apb(1'b0, 12'h020, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      apb(1'b1, ecp_pkg::OFS_DIV, 32'h5);
      apb(1'b0, ecp_pkg::OFS_DIV, 32'h0);
      `CHK("div_low", ecp_pkg::HALF_MIN_CYC, rd[13:0])
      apb(1'b1, ecp_pkg::OFS_DIV, 32'hffff);
      apb(1'b0, ecp_pkg::OFS_DIV, 32'h0);
      `CHK("div_high", 14'(HM), rd[13:0])
      apb(1'b1, ecp_pkg::OFS_DIV, 32'h64);
      apb(1'b1, ecp_pkg::OFS_CTRL, 32'h0);
      idle();
      `CHK("sel_low", 32'h0, rd)
      // a frame clocks the device reset in, then release it
      spi(1'b0, 6'h0, 8'h0);
      dev_rst <= 1'b0;
      for (int a = 16; a < 20; a++) rdc(6'(a));
      for (int a = 0; a < 4; a++) wr(6'(a), 8'($urandom));
      wr(6'h05, 8'($urandom) | 8'h01);
      rdc(6'h05);
      wr(ecp_pkg::ADDR_UNLOCK, ecp_pkg::KEY_UNLOCK);
      for (int a = 4; a < 7; a++) wr(6'(a), 8'($urandom));
      rdc(6'h06);
      for (int i = 0; i < 3; i++) wr(6'(17 + i), keys[i]);
      rdc(ecp_pkg::ADDR_BURN_RSV);
      wr(6'h25, 8'h5a);
      rdc(6'h25);
      // back to readout mode: frames are refused
      apb(1'b1, ecp_pkg::OFS_CTRL, 32'h1);
      idle();
      `CHK("sel_high", 32'h2, rd)
      apb(1'b1, ecp_pkg::OFS_CMD, 32'h10000);
      apb(1'b0, ecp_pkg::OFS_STATUS, 32'h0);
      `CHK("no_frame", 32'h2, rd)
      finish_test();
   end
endmodule
`default_nettype wire

// ### inc/ecp_link_if.sv
// ecp_link_if: the three shared pins plus the protocol select
`timescale 1ns/10ps
`default_nettype none
interface ecp_link_if;
   logic shared_serial_clock_pin;
   logic shared_load_or_serial_input_pin;
   logic protocol_select_input;
   logic dout;
   logic dout_oe_n;
   // output line is pulled high while the device does not drive it
   wire shared_serial_output_pin = dout_oe_n ? 1'b1 : dout;
   modport host (output shared_serial_clock_pin, output shared_load_or_serial_input_pin,
      output protocol_select_input, input shared_serial_output_pin);
   modport dev (input shared_serial_clock_pin, input shared_load_or_serial_input_pin,
      input protocol_select_input, output dout, output dout_oe_n);
endinterface
`default_nettype wire

// ### inc/ecp_pkg.sv
// ecp_pkg: shared constants and types of the encoder configuration port
package ecp_pkg;
   // system clock and serial clock limits
   localparam int SYS_MHZ = 200;
   localparam int SYS_HZ = SYS_MHZ * 1000000;
   localparam int SCLK_MAX_HZ = 1000000;
   localparam int SCLK_MIN_HZ = 10000;
   // half periods: the fastest rounds up, the slowest rounds down
   localparam int HALF_MIN_INT = (SYS_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam int HALF_MAX_INT = SYS_HZ / (2 * SCLK_MIN_HZ);
   localparam logic [13:0] HALF_MIN_CYC = 14'(HALF_MIN_INT);
   // least waits after a select change and after a frame
   localparam int SEL_SETTLE_NS = 1000;
   localparam int GAP_HIGH_NS = 300;
   localparam logic [13:0] SEL_SETTLE_CYC = 14'((SEL_SETTLE_NS * SYS_MHZ + 999) / 1000);
   localparam logic [13:0] GAP_HIGH_CYC = 14'((GAP_HIGH_NS * SYS_MHZ + 999) / 1000);
   // frame layout
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
   localparam logic [3:0] CMD_LAST_BIT = 4'h7;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
   // device register map and keys
   localparam logic [5:0] ADDR_UNLOCK = 6'h10;
   localparam logic [5:0] ADDR_BURN_RSV = 6'h11;
   localparam logic [5:0] ADDR_BURN_ZERO = 6'h12;
   localparam logic [5:0] ADDR_BURN_CFG = 6'h13;
   localparam logic [5:0] ADDR_FREE_LAST_SHADOW = 6'h03;
   localparam logic [5:0] ADDR_FREE_EXTRA = 6'h1b;
   localparam logic [7:0] KEY_UNLOCK = 8'hab;
   localparam logic [7:0] KEY_BURN_RSV = 8'ha1;
   localparam logic [7:0] KEY_BURN_ZERO = 8'ha2;
   localparam logic [7:0] KEY_BURN_CFG = 8'ha3;
   localparam logic [7:0] DEV_REG_RST = 8'h00;
   localparam int NUM_SHADOW = 7;
   localparam int ZERO_FIRST = 2;
   localparam int CFG_FIRST = 4;
   // host apb map
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_CMD = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_RDATA = 12'h00c;
   localparam logic [11:0] OFS_DIV = 12'h010;
   localparam int CMD_WRITE_BIT = 16;
   localparam logic SEL_RST = 1'b1;
   localparam logic [13:0] HALF_RST = HALF_MIN_CYC;
   // one-hot states
   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_SETTLE = 5'b00010,
      H_LOW = 5'b00100,
      H_HIGH = 5'b01000,
      H_GAP = 5'b10000
   } ecp_hst_state_type;
   typedef enum logic [2:0] {
      D_CMD = 3'b001,
      D_WR = 3'b010,
      D_RD = 3'b100
   } ecp_dev_state_type;
endpackage

// ### rtl/ecp_dev.sv
// ecp_dev: device end of the configuration port, clocked by the link clock
`timescale 1ns/10ps
`default_nettype none
module ecp_dev (
   ecp_link_if.dev lnk,
   input wire logic rst_i,
   output logic [55:0] shadow_o,
   output logic [55:0] otp_o,
   output logic unlocked_o
);
   typedef struct packed {
      ecp_pkg::ecp_dev_state_type st;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [7:0] rsh;
      logic [5:0] addr;
      logic [31:0][7:0] regs;
      logic [6:0][7:0] otp;
   } ecp_dev_regs_type;
   localparam ecp_dev_regs_type DEV_RST = '{st: ecp_pkg::D_CMD, default: '0};
   ecp_dev_regs_type r;
   ecp_dev_regs_type n;

   // serial decode, register writes and burns
   always_comb begin
      logic [7:0] rx_byte;
      logic unlocked;
      logic free;
      logic hit;
      rx_byte = {r.sh[6:0], lnk.shared_load_or_serial_input_pin};
      unlocked = (r.regs[ecp_pkg::ADDR_UNLOCK[4:0]] == ecp_pkg::KEY_UNLOCK);
      free = (r.addr <= ecp_pkg::ADDR_FREE_LAST_SHADOW) || (r.addr == ecp_pkg::ADDR_UNLOCK)
         || (r.addr == ecp_pkg::ADDR_BURN_RSV) || (r.addr == ecp_pkg::ADDR_BURN_ZERO)
         || (r.addr == ecp_pkg::ADDR_FREE_EXTRA);
      hit = 1'b0;
      n = r;
      n.cnt = r.cnt + 3'h1;
      if (lnk.protocol_select_input) begin
         // position readout owns the pins, port held idle
         n.st = ecp_pkg::D_CMD;
         n.cnt = 3'h0;
      end else begin
         case (r.st)
            ecp_pkg::D_CMD: begin
               n.sh = rx_byte;
               if (r.cnt == ecp_pkg::BYTE_LAST_BIT) begin
                  n.addr = rx_byte[5:0];
                  if (rx_byte[7:6] == ecp_pkg::OP_READ) begin
                     n.st = ecp_pkg::D_RD;
                     n.rsh = rx_byte[5] ? ecp_pkg::DEV_REG_RST : r.regs[rx_byte[4:0]];
                  end else if (rx_byte[7:6] == ecp_pkg::OP_WRITE) begin
                     n.st = ecp_pkg::D_WR;
                  end
               end
            end
            ecp_pkg::D_WR: begin
               n.sh = rx_byte;
               if (r.cnt == ecp_pkg::BYTE_LAST_BIT) begin
                  n.st = ecp_pkg::D_CMD;
                  if (!r.addr[5] && (free || unlocked)) begin
                     n.regs[r.addr[4:0]] = rx_byte;
                     for (int i = 0; i < ecp_pkg::NUM_SHADOW; i++) begin
                        if (i < ecp_pkg::ZERO_FIRST) begin
                           hit = (r.addr == ecp_pkg::ADDR_BURN_RSV)
                              && (rx_byte == ecp_pkg::KEY_BURN_RSV);
                        end else if (i < ecp_pkg::CFG_FIRST) begin
                           hit = (r.addr == ecp_pkg::ADDR_BURN_ZERO)
                              && (rx_byte == ecp_pkg::KEY_BURN_ZERO);
                        end else begin
                           hit = (r.addr == ecp_pkg::ADDR_BURN_CFG)
                              && (rx_byte == ecp_pkg::KEY_BURN_CFG);
                        end
                        if (hit) begin
                           n.otp[i] = r.regs[i];
                        end
                     end
                  end
               end
            end
            ecp_pkg::D_RD: begin
               // msb first, one bit per clock
               n.rsh = {r.rsh[6:0], 1'b0};
               if (r.cnt == ecp_pkg::BYTE_LAST_BIT) begin
                  n.st = ecp_pkg::D_CMD;
               end
            end
            default: begin
               n.st = ecp_pkg::D_CMD;
            end
         endcase
      end
   end

   // data in is taken on the rising edge of the link clock
   always_ff @(posedge lnk.shared_serial_clock_pin) begin
      if (rst_i) begin
         r <= DEV_RST;
      end else begin
         r <= n;
      end
   end

   // output bit moves on the falling edge
   ecp_dout_stage u_stage (
      .lnk_clk_i(lnk.shared_serial_clock_pin),
      .rst_i(rst_i),
      .bit_i(r.rsh[7]),
      .en_i(r.st == ecp_pkg::D_RD),
      .sel_i(lnk.protocol_select_input),
      .dout_o(lnk.dout),
      .dout_oe_n_o(lnk.dout_oe_n)
   );

   assign shadow_o = r.regs[6:0];
   assign otp_o = r.otp;
   assign unlocked_o = (r.regs[ecp_pkg::ADDR_UNLOCK[4:0]] == ecp_pkg::KEY_UNLOCK);
endmodule
`default_nettype wire

// ### rtl/ecp_dout_stage.sv
// ecp_dout_stage: falling-edge output stage of the device data line
`timescale 1ns/10ps
`default_nettype none
module ecp_dout_stage (
   input wire logic lnk_clk_i,
   input wire logic rst_i,
   input wire logic bit_i,
   input wire logic en_i,
   input wire logic sel_i,
   output logic dout_o,
   output logic dout_oe_n_o
);
   typedef struct packed {
      logic dout;
      logic oe_n;
   } ecp_stage_regs_type;
   ecp_stage_regs_type r;
   ecp_stage_regs_type n;

   // next bit and enable follow the read phase
   always_comb begin
      n.dout = bit_i;
      n.oe_n = ~en_i;
   end

   // update on the falling edge so the bit is stable at the next rise
   always_ff @(negedge lnk_clk_i) begin
      if (rst_i) begin
         r <= '{dout: 1'b1, oe_n: 1'b1};
      end else begin
         r <= n;
      end
   end

   assign dout_o = r.dout;
   // select high hands the pin back to the position readout at once
   assign dout_oe_n_o = r.oe_n | sel_i;
endmodule
`default_nettype wire

// ### rtl/ecp_host.sv
// ecp_host: host controller end of the configuration port, apb slave
//
// Function
// - select low gives pins to configuration
// - select high gives pins to readout
// - serial clock between 10 kHz and 1 MHz
// - read frame is 10 then 6-bit address
// - read returns eight data bits on output
// - device changes output on falling edge
// - host samples read bits on rising edge
// - clock and data idle high
// - clock high while select changes
// - wait 1 us after select change
// - clock high 300 ns between frames
// - write frame is 01, address, data
// - read back written registers to verify
// - key ab at 10 unlocks registers
// - key a1 at 11 burns 00-01
// - key a2 at 12 burns 02-03
// - key a3 at 13 burns 04-06
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ecp_host #(
   parameter int HALF_MAX = ecp_pkg::HALF_MAX_INT
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   ecp_link_if.host lnk
);
   typedef struct packed {
      ecp_pkg::ecp_hst_state_type st;
      logic sel;
      logic sclk;
      logic din;
      logic rd;
      logic [15:0] tx;
      logic [7:0] rx;
      logic [7:0] rdata;
      logic [3:0] bitn;
      logic [13:0] cnt;
      logic [13:0] half;
      logic do_meta;
      logic do_sync;
      logic [31:0] prdata;
   } ecp_hst_regs_type;

   localparam logic [13:0] HALF_MAX_CYC = 14'(HALF_MAX);
   localparam ecp_hst_regs_type HST_RST = '{
      st: ecp_pkg::H_IDLE,
      sel: ecp_pkg::SEL_RST,
      sclk: 1'b1,
      din: 1'b1,
      tx: 16'hffff,
      half: ecp_pkg::HALF_RST,
      default: '0
   };

   ecp_hst_regs_type r;
   ecp_hst_regs_type n;
   logic mapped;
   logic wr_acc;

   // address decode and write strobe of the apb access phase
   always_comb begin
      mapped = (paddr_i == ecp_pkg::OFS_CTRL) || (paddr_i == ecp_pkg::OFS_CMD)
         || (paddr_i == ecp_pkg::OFS_STATUS) || (paddr_i == ecp_pkg::OFS_RDATA)
         || (paddr_i == ecp_pkg::OFS_DIV);
      wr_acc = psel_i && penable_i && pwrite_i && mapped;
   end

   // register file, clock divider and frame sequencer
   always_comb begin
      logic [15:0] frame;
      logic [13:0] wv;
      logic busy;
      n = r;
      busy = (r.st != ecp_pkg::H_IDLE);
      wv = pwdata_i[13:0];
      frame = 16'hffff;
      // returned bit crosses into the system clock
      n.do_meta = lnk.shared_serial_output_pin;
      n.do_sync = r.do_meta;
      if (r.cnt != 14'h0000) begin
         n.cnt = r.cnt - 14'h0001;
      end

      // read data captured in the setup cycle, answered in the access cycle
      if (psel_i && !penable_i) begin
         case (paddr_i)
            ecp_pkg::OFS_CTRL: n.prdata = {31'h0, r.sel};
            ecp_pkg::OFS_STATUS: n.prdata = {30'h0, r.sel, busy};
            ecp_pkg::OFS_RDATA: n.prdata = {24'h0, r.rdata};
            ecp_pkg::OFS_DIV: n.prdata = {18'h0, r.half};
            default: n.prdata = 32'h0;
         endcase
      end

      // divider write clamped to the legal clock range
      if (wr_acc && (paddr_i == ecp_pkg::OFS_DIV)) begin
         if ((pwdata_i[31:14] != 18'h0) || (wv > HALF_MAX_CYC)) begin
            n.half = HALF_MAX_CYC;
         end else if (wv < ecp_pkg::HALF_MIN_CYC) begin
            n.half = ecp_pkg::HALF_MIN_CYC;
         end else begin
            n.half = wv;
         end
      end

      case (r.st)
         // idle: pins rest high until a select change or a frame starts
         ecp_pkg::H_IDLE: begin
            n.sclk = 1'b1;
            n.din = 1'b1;
            if (wr_acc && (paddr_i == ecp_pkg::OFS_CTRL) && (pwdata_i[0] != r.sel)) begin
               // select moves only here, with the clock held high
               n.sel = pwdata_i[0];
               n.cnt = ecp_pkg::SEL_SETTLE_CYC - 14'h0001;
               n.st = ecp_pkg::H_SETTLE;
            end else if (wr_acc && (paddr_i == ecp_pkg::OFS_CMD) && !r.sel) begin
               if (pwdata_i[ecp_pkg::CMD_WRITE_BIT]) begin
                  frame = {ecp_pkg::OP_WRITE, pwdata_i[13:8], pwdata_i[7:0]};
               end else begin
                  frame = {ecp_pkg::OP_READ, pwdata_i[13:8], 8'hff};
               end
               n.rd = ~pwdata_i[ecp_pkg::CMD_WRITE_BIT];
               n.sclk = 1'b0;
               n.din = frame[15];
               n.tx = {frame[14:0], 1'b1};
               n.bitn = 4'h0;
               n.cnt = r.half - 14'h0001;
               n.st = ecp_pkg::H_LOW;
            end
         end
         // settle: no frame until the device has switched protocols
         ecp_pkg::H_SETTLE: begin
            if (r.cnt == 14'h0000) begin
               n.st = ecp_pkg::H_IDLE;
            end
         end
         // low half: the rising edge ends it and takes a read bit
         ecp_pkg::H_LOW: begin
            if (r.cnt == 14'h0000) begin
               n.sclk = 1'b1;
               n.cnt = r.half - 14'h0001;
               n.st = ecp_pkg::H_HIGH;
               if (r.rd && (r.bitn > ecp_pkg::CMD_LAST_BIT)) begin
                  n.rx = {r.rx[6:0], r.do_sync};
               end
            end
         end
         // high half: next bit out, or the frame is over
         ecp_pkg::H_HIGH: begin
            if (r.cnt == 14'h0000) begin
               if (r.bitn == ecp_pkg::FRAME_LAST_BIT) begin
                  n.cnt = ecp_pkg::GAP_HIGH_CYC - 14'h0001;
                  n.st = ecp_pkg::H_GAP;
                  if (r.rd) begin
                     n.rdata = r.rx;
                  end
               end else begin
                  // next bit goes out with the falling edge
                  n.bitn = r.bitn + 4'h1;
                  n.sclk = 1'b0;
                  n.din = r.tx[15];
                  n.tx = {r.tx[14:0], 1'b1};
                  n.cnt = r.half - 14'h0001;
                  n.st = ecp_pkg::H_LOW;
               end
            end
         end
         // gap: clock stays high so back to back frames stay apart
         ecp_pkg::H_GAP: begin
            n.din = 1'b1;
            if (r.cnt == 14'h0000) begin
               n.st = ecp_pkg::H_IDLE;
            end
         end
         default: begin
            n.st = ecp_pkg::H_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         r <= HST_RST;
      end else begin
         r <= n;
      end
   end

   // apb answers in the access cycle, unmapped addresses give an error
   assign pready_o = psel_i && penable_i;
   assign pslverr_o = psel_i && penable_i && !mapped;
   assign prdata_o = r.prdata;
   assign lnk.shared_serial_clock_pin = r.sclk;
   assign lnk.shared_load_or_serial_input_pin = r.din;
   assign lnk.protocol_select_input = r.sel;
endmodule
`default_nettype wire
